// file: svif_irq_ctrl.v
`include "svif_map.vh"
`default_nettype none
module svif_irq_ctrl (
    input wire clk_in,
    input wire reset_n_in,
    // Event sources, synchronous to clk_in
    input wire ext0_pin_in,
    input wire ext1_pin_in,
    input wire timer_a_overflow_in,
    input wire timer_b_overflow_in,
    input wire timer_counter_overflow_in,
    input wire sync_serial_port_done_in,
    input wire comparator_a_level_in,
    input wire comparator_b_level_in,
    input wire uart_rx_done_in,
    input wire uart_tx_done_in,
    // Configuration written by software
    input wire ext0_edge_select_in,
    input wire global_irq_enable_wr_in,
    input wire global_irq_enable_data_in,
    input wire [`SVIF_NUM_SRC-1:0] enable_wr_in,
    input wire [`SVIF_NUM_SRC-1:0] enable_data_in,
    input wire [`SVIF_NUM_SRC-1:0] flag_wr_in,
    input wire [`SVIF_NUM_SRC-1:0] flag_data_in,
    // Core acknowledges taking the vector
    input wire vector_ack_in,
    // State readback
    output reg global_irq_enable_out,
    output reg [`SVIF_NUM_SRC-1:0] enable_out,
    output reg [`SVIF_NUM_SRC-1:0] flag_out,
    output reg irq_request_out,
    output reg [15:0] vector_addr_out
);
    // Timing at the ports, for an event sampled at clock edge N:
    //   edge N: the flag cell sets, even when that cycle also writes a zero to it
    //   edge N+1: flag_out shows the flag, and irq_request_out rises if both enables are set
    //   edge N+2 at the earliest: the core may acknowledge the request
    //   edge after the acknowledge: the request drops and the global enable clears
    //   the vector address never changes; it sits in a flop like every other output
    // Limits worth knowing:
    //   pin and comparator levels are taken as synchronous; a raw pin needs a synchroniser first
    //   a completion input held high sets its flag every cycle, so a clear cannot stick meanwhile
    //   the edge detectors start low, so a high level at reset release counts as a rise
    //   a write of one to a flag is ignored; only hardware events set flags
    //   there is no ranking: software polls the enable and flag pairs in its own order

    // Edge pulses from the pin and comparator detectors
    wire ext0_rise; // External 0 pin went high
    wire ext0_fall; // External 0 pin went low
    wire ext1_fall; // External 1 pin went low
    wire cmpa_rise; // Comparator A output went high
    wire cmpa_fall; // Comparator A output went low
    wire cmpb_rise; // Comparator B output went high
    wire cmpb_fall; // Comparator B output went low

    // One-cycle event strobes per source, before they reach the flags
    reg ext0_event; // Only the edge named by the select bit
    wire ext1_event; // Falling edge only
    wire timer_a_event; // First timer wrapped
    wire timer_b_event; // Second timer wrapped
    wire timer_counter_event; // Timer-counter wrapped
    wire serial_event; // Synchronous serial transfer finished
    wire cmpa_event; // Comparator A changed level
    wire cmpb_event; // Comparator B changed level
    wire uart_rx_event; // UART byte received
    wire uart_tx_event; // UART byte sent

    // Packed set strobes and the live state of the flag cells
    reg [`SVIF_NUM_SRC-1:0] set_vec;
    wire [`SVIF_NUM_SRC-1:0] flag_q;
    // Software clears only on a written zero; a written one leaves the flag alone
    wire [`SVIF_NUM_SRC-1:0] clear_vec;
    // Next values of the registered outputs
    reg next_global_irq_enable; // Global enable after this edge
    reg [`SVIF_NUM_SRC-1:0] next_enable; // Per-source enables after this edge
    reg next_irq_request; // Request line after this edge

    // Any enabled pending source; deliberately no ranking among them
    function any_pending;
        input [`SVIF_NUM_SRC-1:0] flags;
        input [`SVIF_NUM_SRC-1:0] enables;
        begin
            any_pending = |(flags & enables);
        end
    endfunction

    // Either-direction change of a level, from its two edge pulses
    function level_changed;
        input rise;
        input fall;
        begin
            level_changed = rise | fall;
        end
    endfunction

    // Bitwise write merge: strobed bits take the new value, the others keep theirs
    function [`SVIF_NUM_SRC-1:0] merge_bits;
        input [`SVIF_NUM_SRC-1:0] old_bits;
        input [`SVIF_NUM_SRC-1:0] new_bits;
        input [`SVIF_NUM_SRC-1:0] strobes;
        begin
            merge_bits = (old_bits & ~strobes) | (new_bits & strobes);
        end
    endfunction

    // External 0 pin; both edges come out and the select bit picks one below
    svif_edge_det u_ext0 (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .level_in(ext0_pin_in),
        .rise_out(ext0_rise),
        .fall_out(ext0_fall)
    );
    // External 1 pin; only the fall is wanted, the rise output stays open
    svif_edge_det u_ext1 (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .level_in(ext1_pin_in),
        .rise_out(),
        .fall_out(ext1_fall)
    );
    // Comparator A output level
    svif_edge_det u_cmpa (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .level_in(comparator_a_level_in),
        .rise_out(cmpa_rise),
        .fall_out(cmpa_fall)
    );
    // Comparator B output level
    svif_edge_det u_cmpb (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .level_in(comparator_b_level_in),
        .rise_out(cmpb_rise),
        .fall_out(cmpb_fall)
    );

    // External 0: the select bit picks the edge that counts; the other is dropped
    always @* begin
        case (ext0_edge_select_in)
            `SVIF_EDGE_RISING: begin
                ext0_event = ext0_rise;
            end
            `SVIF_EDGE_FALLING: begin
                ext0_event = ext0_fall;
            end
            default: begin
                // An unknown select sets nothing rather than guess an edge
                ext0_event = `SVIF_BIT_RST;
            end
        endcase
    end

    // External 1 has a fixed falling edge
    assign ext1_event = ext1_fall;

    // Timer wraps arrive as one-cycle pulses from the timers
    assign timer_a_event = timer_a_overflow_in;
    assign timer_b_event = timer_b_overflow_in;
    assign timer_counter_event = timer_counter_overflow_in;

    // Serial completion pulse; a held level would set the flag again every cycle
    assign serial_event = sync_serial_port_done_in;

    // Comparator flags follow any change of the output level, not one edge
    assign cmpa_event = level_changed(cmpa_rise, cmpa_fall);
    assign cmpb_event = level_changed(cmpb_rise, cmpb_fall);

    // UART completion pulses, one per direction
    assign uart_rx_event = uart_rx_done_in;
    assign uart_tx_event = uart_tx_done_in;

    // Pack the strobes in the shared bit order; no enable bit gates them
    always @* begin
        // Start from all clear so every bit has a value on every path
        set_vec = `SVIF_FLAGS_RST;
        set_vec[`SVIF_BIT_EXT0] = ext0_event;
        set_vec[`SVIF_BIT_EXT1] = ext1_event;
        set_vec[`SVIF_BIT_TMRA] = timer_a_event;
        set_vec[`SVIF_BIT_TMRB] = timer_b_event;
        set_vec[`SVIF_BIT_TMRC] = timer_counter_event;
        set_vec[`SVIF_BIT_SSP] = serial_event;
        set_vec[`SVIF_BIT_CMPA] = cmpa_event;
        set_vec[`SVIF_BIT_CMPB] = cmpb_event;
        set_vec[`SVIF_BIT_URX] = uart_rx_event;
        set_vec[`SVIF_BIT_UTX] = uart_tx_event;
    end

    // Clear strobes from software writes of zero
    assign clear_vec = flag_wr_in & ~flag_data_in;

    // One sticky flag per source; an event in the clear cycle survives the clear
    // Loop index over the flag cells
    genvar gi;
    generate
        for (gi = 0; gi < `SVIF_NUM_SRC; gi = gi + 1) begin : g_flag
            // Cell gi holds the flag of source gi in the shared bit order
            svif_flag_bit u_flag (
                .clk_in(clk_in),
                .reset_n_in(reset_n_in),
                .set_in(set_vec[gi]),
                .clear_in(clear_vec[gi]),
                .flag_out(flag_q[gi])
            );
        end
    endgenerate

    // Global enable: the core's entry acknowledge clears it and beats a software write
    always @* begin
        if (vector_ack_in) begin
            // Masks nesting until the handler turns it back on
            next_global_irq_enable = `SVIF_BIT_RST;
        end else if (global_irq_enable_wr_in) begin
            // Software write of the global enable
            next_global_irq_enable = global_irq_enable_data_in;
        end else begin
            // No write: hold
            next_global_irq_enable = global_irq_enable_out;
        end
    end

    // Per-source enables: only the strobed bits change
    always @* begin
        // Bits without a strobe keep their value
        next_enable = merge_bits(enable_out, enable_data_in, enable_wr_in);
    end

    // Request needs global enable plus a matching enable and flag; sources are not ranked
    always @* begin
        // Global gate first, then any enabled flag
        next_irq_request = global_irq_enable_out & any_pending(flag_q, enable_out);
        if (vector_ack_in) begin
            // Dropped on entry so the core does not take the same request twice
            next_irq_request = `SVIF_BIT_RST;
        end
    end

    // Global enable register; reset keeps the core out until software is ready
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            // Nothing is taken before software turns it on
            global_irq_enable_out <= `SVIF_BIT_RST;
        end else begin
            global_irq_enable_out <= next_global_irq_enable;
        end
    end

    // Per-source enable register
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            // Every source starts disabled
            enable_out <= `SVIF_FLAGS_RST;
        end else begin
            enable_out <= next_enable;
        end
    end

    // Flag readback: a copy of the flag cells one cycle behind, so the port is flop-driven
    // Software that polls right after an event may see the flag one cycle late
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            // No request is pending after reset
            flag_out <= `SVIF_FLAGS_RST;
        end else begin
            flag_out <= flag_q;
        end
    end

    // Request register toward the core
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            // Quiet line while in reset
            irq_request_out <= `SVIF_BIT_RST;
        end else begin
            irq_request_out <= next_irq_request;
        end
    end

    // Shared vector address; a constant, but kept in a flop like every other output
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            // Valid even while in reset
            vector_addr_out <= `SVIF_VECTOR_ADDR;
        end else begin
            vector_addr_out <= `SVIF_VECTOR_ADDR;
        end
    end
endmodule // svif_irq_ctrl
`default_nettype wire

// file: svif_map.vh
`ifndef SVIF_MAP_VH
`define SVIF_MAP_VH
// Number of request sources and their bit positions in the packed vectors
`define SVIF_NUM_SRC 10
`define SVIF_BIT_EXT0 0
`define SVIF_BIT_EXT1 1
`define SVIF_BIT_TMRA 2
`define SVIF_BIT_TMRB 3
`define SVIF_BIT_TMRC 4
`define SVIF_BIT_SSP 5
`define SVIF_BIT_CMPA 6
`define SVIF_BIT_CMPB 7
`define SVIF_BIT_URX 8
`define SVIF_BIT_UTX 9
// Shared interrupt vector address
`define SVIF_VECTOR_ADDR 16'h0008
// Reset values
`define SVIF_FLAGS_RST 10'h000
`define SVIF_BIT_RST 1'b0
// Edge select encoding for external input 0
`define SVIF_EDGE_RISING 1'b0
`define SVIF_EDGE_FALLING 1'b1
`endif

// file: svif_edge_det.v
`include "svif_map.vh"
`default_nettype none
// Edge detector on a synchronous level; reports rise and fall as one-cycle pulses
module svif_edge_det (
    input wire clk_in,
    input wire reset_n_in,
    input wire level_in,
    output wire rise_out,
    output wire fall_out
);
    // Previous sampled level
    reg level_q;

    // Hold last level; starts low so a high level at release reads as a rise
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            level_q <= `SVIF_BIT_RST;
        end else begin
            level_q <= level_in;
        end
    end

    assign rise_out = level_in & ~level_q;
    assign fall_out = ~level_in & level_q;
endmodule // svif_edge_det
`default_nettype wire

// file: svif_flag_bit.v
`include "svif_map.vh"
`default_nettype none
// One sticky request flag: hardware set wins over a software clear
module svif_flag_bit (
    input wire clk_in,
    input wire reset_n_in,
    input wire set_in,
    input wire clear_in,
    output reg flag_out
);
    // Set has priority so an event in the clear cycle is kept
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flag_out <= `SVIF_BIT_RST;
        end else if (set_in) begin
            flag_out <= 1'b1;
        end else if (clear_in) begin
            flag_out <= 1'b0;
        end
    end
endmodule // svif_flag_bit
`default_nettype wire

// file: svif_irq_ctrl_sva.sv
`include "svif_map.vh"
`default_nettype none
// Port-side checks of the shared request logic
module svif_irq_ctrl_sva (
    input wire clk_in,
    input wire reset_n_in,
    input wire ext1_pin_in,
    input wire timer_a_overflow_in,
    input wire sync_serial_port_done_in,
    input wire comparator_a_level_in,
    input wire uart_tx_done_in,
    input wire vector_ack_in,
    input wire global_irq_enable_out,
    input wire [`SVIF_NUM_SRC-1:0] enable_out,
    input wire [`SVIF_NUM_SRC-1:0] flag_out,
    input wire irq_request_out,
    input wire [15:0] vector_addr_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    reset_vals_a: assert property ($rose(reset_n_in) |-> !flag_out && !enable_out && !global_irq_enable_out)
        else $error("state not clear after reset");
    vector_fixed_a: assert property (vector_addr_out == `SVIF_VECTOR_ADDR) else $error("vector moved");
    serial_set_a: assert property (sync_serial_port_done_in |-> ##2 flag_out[5]) else $error("serial flag");
    uart_set_a: assert property (uart_tx_done_in |-> ##2 flag_out[9]) else $error("uart flag");
    timer_set_a: assert property (timer_a_overflow_in |-> ##2 flag_out[2]) else $error("timer flag");
    ext1_fall_a: assert property ($fell(ext1_pin_in) |-> ##[2:3] flag_out[1]) else $error("ext1 flag");
    cmp_change_a: assert property ($changed(comparator_a_level_in) |-> ##[2:3] flag_out[6]) else $error("cmp");
    // Flags show one cycle late, so they line up with the enables of the cycle before
    irq_cause_a: assert property (irq_request_out |->
        |(flag_out & $past(enable_out)) && $past(global_irq_enable_out)) else $error("request without cause");
    irq_taken_a: assert property (|(flag_out & $past(enable_out)) && $past(global_irq_enable_out)
        && !$past(vector_ack_in) |-> irq_request_out) else $error("request missing");
    cover property (irq_request_out && vector_ack_in);
    cover property ($rose(flag_out[0]));
    cover property (flag_out[5] && !irq_request_out);
endmodule // svif_irq_ctrl_sva
bind svif_irq_ctrl svif_irq_ctrl_sva chk (.*);
`default_nettype wire

// file: svif_core_model.sv
`default_nettype none
// Core: enters the vector once per request, at once or after a stall
module svif_core_model (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic irq_in,
    input wire logic slow_in,
    output logic ack_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] wait_cnt; // Cycles the request has waited
    // Ack lasts one cycle, so a second entry needs a fresh request
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wait_cnt <= 3'h0;
            ack_out <= 1'b0;
        end else begin
            wait_cnt <= (irq_in && !ack_out) ? wait_cnt + 3'h1 : 3'h0;
            ack_out <= irq_in && !ack_out && wait_cnt >= (slow_in ? 3'h3 : 3'h0);
        end
    end
endmodule // svif_core_model
`default_nettype wire

// file: test_svif_irq_ctrl.sv
`include "svif_map.vh"
`default_nettype none
module test_svif_irq_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 0, reset_n_in = 0, ext0_edge_select_in = 0, global_irq_enable_wr_in = 0, slow = 0;
    logic global_irq_enable_data_in = 0, vector_ack_in, global_irq_enable_out, irq_request_out;
    logic [9:0] enable_wr_in = 0, enable_data_in = 0, flag_wr_in = 0, flag_data_in = 0, ev = 0;
    logic [9:0] enable_out, flag_out, last = 0;
    logic [15:0] vector_addr_out;
    logic [10:0] note[$]; // Expected {request, flags} at each flag change
    int fail_count = 0, checked = 0, cyc = 0;
    integer seed = 32'hf065_1d1f;
    always #5 clk_in = ~clk_in;
    // Event bits: 0, 1, 6, 7 are levels, the rest one-cycle pulses
    svif_irq_ctrl dut (.ext0_pin_in(ev[0]), .ext1_pin_in(ev[1]), .timer_a_overflow_in(ev[2]),
        .timer_b_overflow_in(ev[3]), .timer_counter_overflow_in(ev[4]), .sync_serial_port_done_in(ev[5]),
        .comparator_a_level_in(ev[6]), .comparator_b_level_in(ev[7]), .uart_rx_done_in(ev[8]),
        .uart_tx_done_in(ev[9]), .*);
    svif_core_model core (.clk_in, .reset_n_in, .irq_in(irq_request_out), .slow_in(slow), .ack_out(vector_ack_in));
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("counts: %0d checked, %0d wrong", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // A change with no note pending compares against unknown and so counts as wrong
    always @(negedge clk_in) begin
        if (reset_n_in && flag_out !== last) begin
            last = flag_out;
            chk({irq_request_out, flag_out}, note.size() ? note.pop_front() : 11'hx);
        end
    end
    always @(posedge clk_in) begin
        if (++cyc > 2000) begin
            fail_count++;
            $display("wrong value at %0t: run timed out", $time);
            end_sim;
        end
    end
    // One event with random gates; software then clears every flag
    task automatic fire(input int b);
        logic [9:0] en;
        logic g, lv, sel, hit;
        en = 10'($random(seed));
        g = 1'($random(seed));
        sel = 1'($random(seed));
        lv = !ev[b];
        hit = (b == 0) ? lv ^ sel : (b == 1) ? !lv : 1'b1;
        @(posedge clk_in);
        enable_wr_in <= 10'h3ff;
        enable_data_in <= en;
        global_irq_enable_wr_in <= 1'b1;
        global_irq_enable_data_in <= g;
        ext0_edge_select_in <= sel;
        slow <= 1'($random(seed));
        @(posedge clk_in);
        enable_wr_in <= 10'h000;
        global_irq_enable_wr_in <= 1'b0;
        ev[b] <= lv;
        if (hit) note.push_back({en[b] & g, 10'h001 << b});
        @(posedge clk_in);
        if (b inside {[2:5], 8, 9}) ev[b] <= 1'b0;
        repeat (7) @(posedge clk_in);
        @(negedge clk_in);
        // Enables read back as written; a taken request has cleared the global enable
        chk({global_irq_enable_out, enable_out}, {g & !(hit & en[b]), en});
        @(posedge clk_in);
        flag_wr_in <= 10'h3ff;
        if (hit) note.push_back(11'h000);
        @(posedge clk_in);
        flag_wr_in <= 10'h000;
    endtask
    initial begin
        repeat (20) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(negedge clk_in);
        chk({global_irq_enable_out, enable_out, flag_out}, 21'h0);
        chk(vector_addr_out, 16'h0008);
        $display("reset test done");
        for (int i = 0; i < 30; i++) fire(i % 10);
        repeat (3) @(posedge clk_in);
        chk(note.size(), 0);
        $display("event sweep done");
        end_sim;
    end
endmodule // test_svif_irq_ctrl
`default_nettype wire
